// ===== hw/rate_scheduler.sv
/*
 * Conversion rate scheduler: runs conversion sequences over the enabled
 * channels and paces them by the rate register.
 * Assumes enables, halt and one-shot come from logic on CLOCK; the two
 * address select pins are asynchronous.
 */
`timescale 1ns/1ps
`include "sched_defines.svh"
module rate_scheduler #(
   parameter int unsigned CONV_CYCLES = `CONV_CYCLES
) (
   // Clock, reset, enable
   input  wire logic                  CLOCK,
   input  wire logic                  NRST,
   input  wire logic                  CLK_EN,
   // Register port
   input  wire logic [7:0]            REG_PTR,
   input  wire logic [7:0]            REG_WDATA,
   input  wire logic                  REG_WR,
   output      logic [7:0]            REG_RDATA,
   // Channel control
   input  wire logic                  LOCAL_CHANNEL_ON,
   input  wire logic                  REMOTE1_CHANNEL_ON,
   input  wire logic                  REMOTE2_CHANNEL_ON,
   input  wire logic                  REMOTE3_CHANNEL_ON,
   input  wire logic                  HALT_CONVERSIONS,
   input  wire logic                  ONESHOT,
   // Address select pins
   input  wire logic                  TARGET_ADDR_SEL_HI,
   input  wire logic                  TARGET_ADDR_SEL_LO,
   output      logic [6:0]            TARGET_ADDR,
   // Status
   output      logic                  BUSY,
   output      sched_pkg::chan_idx_type CHAN_ACTIVE,
   output      logic                  CHAN_START,
   output      logic                  SEQ_DONE
);
   import sched_pkg::*;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   sched_state_type state_q, state_d;
   chan_idx_type    chan_q, chan_d;
   logic [31:0]     per_q, per_d;
   logic [7:0]      rate_q, rate_d;
   logic [7:0]      rdata_q, rdata_d;
   logic            busy_q, busy_d;
   logic            start_q, start_d;
   logic            done_q, done_d;
   logic [1:0]      sel_s1_q, sel_s2_q;
   logic [6:0]      addr_q;
   logic [3:0]      en;
   logic [31:0]     nominal;
   logic [2:0]      code;
   logic            seq_go;
   logic [2:0]      nxt;
   logic [2:0]      first;
   tmr_if           tmr ();

   assign en = {REMOTE3_CHANNEL_ON, REMOTE2_CHANNEL_ON,
                REMOTE1_CHANNEL_ON, LOCAL_CHANNEL_ON};
   assign code = rate_q[`RATE_CODE_MSB:0];

   // Lowest enabled channel at or above from; bit 2 marks found
   function automatic logic [2:0] pick_on(input logic [3:0] e,
                                          input logic [2:0] from);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 3; i >= 0; i--) begin
         if (e[i] && (3'(i) >= from)) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   // -------------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------------

   always_comb begin
      rate_d = rate_q;
      if (REG_WR && (REG_PTR == `RATE_PTR)) begin
         rate_d = REG_WDATA;
      end
      rdata_d = (REG_PTR == `RATE_PTR) ? rate_q : `READ_UNMAPPED;
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         rate_q  <= `RATE_RESET;
         rdata_q <= `READ_UNMAPPED;
      end else if (CLK_EN) begin
         rate_q  <= rate_d;
         rdata_q <= rdata_d;
      end
   end

   // -------------------------------------------------------------------
   // Scheduler
   // -------------------------------------------------------------------

   // nominal period, 128 slots at code 0
   assign nominal = 32'(CONV_CYCLES) << (`RATE_CODE_MAX - code);

   assign nxt   = pick_on(en, {1'b0, chan_q} + 3'h1);
   assign first = pick_on(en, 3'h0);

   // Next state of the sequence engine
   always_comb begin
      state_d      = state_q;
      chan_d       = chan_q;
      per_d        = (per_q != 32'h0) ? per_q - 32'h1 : per_q;
      start_d      = 1'b0;
      done_d       = 1'b0;
      seq_go       = 1'b0;
      tmr.load     = 1'b0;
      tmr.load_val = 32'(CONV_CYCLES);
      case (state_q)
         ST_CONVERT: begin
            if (tmr.expired) begin
               if (nxt[2]) begin
                  chan_d   = nxt[1:0];
                  tmr.load = 1'b1;
                  start_d  = 1'b1;
               end else begin
                  done_d = 1'b1;
                  state_d = HALT_CONVERSIONS ? ST_HALTED : ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (ONESHOT || ((per_q <= 32'h1) && !HALT_CONVERSIONS)) begin
               seq_go = 1'b1;
            end else if (HALT_CONVERSIONS) begin
               state_d = ST_HALTED;
            end
         end
         ST_HALTED: begin
            // resume on clear, single run on one-shot
            if (ONESHOT || !HALT_CONVERSIONS) begin
               seq_go = 1'b1;
            end
         end
         default: begin
            state_d = ST_WAIT;
         end
      endcase
      if (seq_go) begin
         per_d = nominal;
         if (first[2]) begin
            chan_d   = first[1:0];
            tmr.load = 1'b1;
            start_d  = 1'b1;
            state_d  = ST_CONVERT;
         end else begin
            state_d = HALT_CONVERSIONS ? ST_HALTED : ST_WAIT;
         end
      end
      busy_d = (state_d == ST_CONVERT);
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         state_q <= ST_WAIT;
         chan_q  <= 2'h0;
         per_q   <= 32'h0;
         busy_q  <= 1'b0;
         start_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (CLK_EN) begin
         state_q <= state_d;
         chan_q  <= chan_d;
         per_q   <= per_d;
         busy_q  <= busy_d;
         start_q <= start_d;
         done_q  <= done_d;
      end
   end

   conv_timer u_timer (
      .clk   (CLOCK),
      .rst_n (NRST),
      .ce    (CLK_EN),
      .t     (tmr.tmr)
   );

   // -------------------------------------------------------------------
   // Target address
   // -------------------------------------------------------------------

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         sel_s1_q <= 2'h0;
         sel_s2_q <= 2'h0;
         addr_q   <= `ADDR_BASE;
      end else if (CLK_EN) begin
         sel_s1_q <= {TARGET_ADDR_SEL_HI, TARGET_ADDR_SEL_LO};
         sel_s2_q <= sel_s1_q;
         addr_q   <= {5'(`ADDR_BASE >> 2), sel_s2_q};
      end
   end

   assign REG_RDATA   = rdata_q;
   assign TARGET_ADDR = addr_q;
   assign BUSY        = busy_q;
   assign CHAN_ACTIVE = chan_q;
   assign CHAN_START  = start_q;
   assign SEQ_DONE    = done_q;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   logic [31:0] len_q;
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         len_q <= 32'h0;
      end else if (CLK_EN) begin
         len_q <= CHAN_START ? 32'h1 : len_q + 32'h1;
      end
   end

   property p_rate_wr;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && REG_WR && REG_PTR == `RATE_PTR) |=> rate_q == $past(REG_WDATA);
   endproperty
   a_rate_wr: assert property (p_rate_wr) else $error("rate write lost");

   property p_conv_len;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && BUSY && tmr.expired) |-> len_q == 32'(CONV_CYCLES) - 32'h1;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length");

   property p_oneshot;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && state_q == ST_WAIT && ONESHOT && |en) |=> CHAN_START && BUSY;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot ignored");

   property p_slow;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && seq_go && code == 3'h0) |=> per_q == 32'(CONV_CYCLES) * 128;
   endproperty
   a_slow: assert property (p_slow) else $error("code 0 period");

   property p_mid;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && seq_go && code == 3'h5) |=> per_q == 32'(CONV_CYCLES) * 4;
   endproperty
   a_mid: assert property (p_mid) else $error("code 5 period");

   property p_fast6;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && seq_go && code == 3'h6) |=> per_q == 32'(CONV_CYCLES) * 2;
   endproperty
   a_fast6: assert property (p_fast6) else $error("code 6 period");

   property p_fast7;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && seq_go && code == 3'h7) |=> per_q == 32'(CONV_CYCLES);
   endproperty
   a_fast7: assert property (p_fast7) else $error("code 7 period");

   property p_addr;
      @(posedge CLOCK) disable iff (!NRST)
      ($past(CLK_EN, 1) && $past(CLK_EN, 2) && $past(CLK_EN, 3))
      |-> TARGET_ADDR[1:0] ==
          $past({TARGET_ADDR_SEL_HI, TARGET_ADDR_SEL_LO}, 3);
   endproperty
   a_addr: assert property (p_addr) else $error("address select");

   property p_order;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && BUSY && tmr.expired && nxt[2]) |=>
         CHAN_START && CHAN_ACTIVE > $past(CHAN_ACTIVE) &&
         (($past(en) >> CHAN_ACTIVE) & 4'h1) == 4'h1;
   endproperty
   a_order: assert property (p_order) else $error("channel order");

   property p_halt;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && state_q == ST_HALTED && HALT_CONVERSIONS && !ONESHOT)
      |=> !BUSY;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not held");

   property p_busy;
      @(posedge CLOCK) disable iff (!NRST)
      $rose(BUSY) |-> CHAN_START && $past(state_q) != ST_CONVERT;
   endproperty
   a_busy: assert property (p_busy) else $error("busy rise");

   property p_period;
      @(posedge CLOCK) disable iff (!NRST)
      (CLK_EN && state_q == ST_WAIT && per_q <= 32'h1 &&
       !HALT_CONVERSIONS && |en) |=> CHAN_START;
   endproperty
   a_period: assert property (p_period) else $error("late sequence");
endmodule

// ===== hw/sched_defines.svh
/*
 * Constants of the conversion rate scheduler: pointer offsets, reset
 * values, field positions and timing counts.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef SCHED_DEFINES_SVH
`define SCHED_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RATE_PTR        8'h0B
`define RATE_RESET      8'h07
`define READ_UNMAPPED   8'h00
`define RATE_CODE_MSB   2
`define RATE_CODE_MAX   3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ         100
`define CONV_TIME_US    125000
`define CONV_CYCLES     (`CONV_TIME_US * `CLK_MHZ)

// ----------------------------------------------------------------------
// Target address (arbitrary value)
// ----------------------------------------------------------------------
`define ADDR_BASE       7'h28

`endif

// ===== hw/sched_pkg.sv
/*
 * Types shared by the scheduler modules.
 * Assumes nothing of its surroundings.
 */
package sched_pkg;
   // Scheduler states
   typedef enum logic [1:0] {
      ST_CONVERT,
      ST_WAIT,
      ST_HALTED
   } sched_state_type;

   // Channel index: local, remote 1, remote 2, remote 3
   typedef logic [1:0] chan_idx_type;
endpackage

// ===== hw/tmr_if.sv
/*
 * Carrier between the scheduler and its conversion timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface tmr_if;
   logic        load;
   logic [31:0] load_val;
   logic        expired;

   modport ctl (output load, output load_val, input expired);
   modport tmr (input load, input load_val, output expired);
endinterface

// ===== hw/conv_timer.sv
/*
 * Per-channel conversion timer: loaded with a cycle count, flags the
 * last cycle of the count.
 * Assumes a load value of at least two cycles.
 */
`timescale 1ns/1ps
module conv_timer (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Control side
   tmr_if.tmr        t
);
   logic [31:0] count_q;
   logic [31:0] count_d;

   // Next count: load or count down to zero
   always_comb begin
      count_d = count_q;
      if (t.load) begin
         count_d = t.load_val;
      end else if (count_q != 32'h0) begin
         count_d = count_q - 32'h1;
      end
   end

   // Count register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 32'h0;
      end else if (ce) begin
         count_q <= count_d;
      end
   end

   // Last cycle of the conversion
   assign t.expired = (count_q == 32'h1);
endmodule

// ===== test/reg_host.sv
/*
 * Register host model: pointer writes and registered reads.
 * Assumes read data follows the pointer one edge later.
 */
`timescale 1ns/1ps
module reg_host (
   // Clock
   input  wire logic       clk,
   // Register port
   output      logic [7:0] ptr,
   output      logic [7:0] wdata,
   output      logic       wr,
   input  wire logic [7:0] rdata,
   // Read result
   output      logic       rd_vld,
   output      logic [7:0] rd_val
);
   // Quiet port at time zero
   initial begin
      ptr    = 8'h00;
      wdata  = 8'h00;
      wr     = 1'b0;
      rd_vld = 1'b0;
      rd_val = 8'h00;
   end

   task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
      @(posedge clk) #1;
      ptr   = p;
      wdata = d;
      wr    = 1'b1;
      @(posedge clk) #1;
      wr    = 1'b0;
      wdata = ~d; // Stale data not kept
   endtask

   task automatic rd_reg(input logic [7:0] p);
      @(posedge clk) #1;
      ptr = p;
      @(posedge clk) #1;
      rd_val = rdata;
      rd_vld = 1'b1;
      @(posedge clk) #1;
      rd_vld = 1'b0;
   endtask
endmodule

// ===== test/tb_top.sv
/*
 * Self-checking bench of the rate scheduler with a register host.
 * Assumes a short conversion count so that every rate fits the run.
 */
`timescale 1ns/1ps
`include "sched_defines.svh"
module tb_top;
   import sched_pkg::*;
   localparam int N = 20;
   typedef struct {string nm; logic [15:0] v;} note_type;

   // ------------------------------
   // Signals and instances
   // ------------------------------
   logic         clk     = 1'b0;
   logic         rst_n   = 1'b0;
   logic         oneshot = 1'b0;
   logic         halt    = 1'b0;
   logic         ce      = 1'b1;
   logic [3:0]   chan_on = 4'h0;
   logic [1:0]   sel     = 2'h0;
   logic [7:0]   ptr, wdata, rdata, rd_val;
   logic         wr, rd_vld, busy, start, done;
   logic [6:0]   addr;
   chan_idx_type act;
   note_type     nq[$];
   logic [31:0]  seed    = 32'h9AA1C8B3;
   logic         obs     = 1'b0;
   logic [15:0]  obs_v   = 16'h0000;
   int           num_errors = 0;
   int           cmp_count  = 0;
   int           go_n       = 0;

   reg_host host (.clk(clk), .ptr(ptr), .wdata(wdata), .wr(wr),
      .rdata(rdata), .rd_vld(rd_vld), .rd_val(rd_val));
   rate_scheduler #(.CONV_CYCLES(N)) uut (.CLOCK(clk), .NRST(rst_n),
      .CLK_EN(ce), .REG_PTR(ptr), .REG_WDATA(wdata), .REG_WR(wr),
      .REG_RDATA(rdata), .LOCAL_CHANNEL_ON(chan_on[0]),
      .REMOTE1_CHANNEL_ON(chan_on[1]), .REMOTE2_CHANNEL_ON(chan_on[2]),
      .REMOTE3_CHANNEL_ON(chan_on[3]), .HALT_CONVERSIONS(halt),
      .ONESHOT(oneshot), .TARGET_ADDR_SEL_HI(sel[1]),
      .TARGET_ADDR_SEL_LO(sel[0]), .TARGET_ADDR(addr), .BUSY(busy),
      .CHAN_ACTIVE(act), .CHAN_START(start), .SEQ_DONE(done));

   // Clock of 10 ns
   always #5 clk = ~clk;

   // ------------------------------
   // Helpers
   // ------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic push(string n, logic [15:0] v);
      nq.push_back('{n, v});
   endtask

   // Oldest note against a result
   task automatic take(logic [15:0] v);
      note_type e;
      cmp_count++;
      if (nq.size() == 0) begin
         num_errors++;
         $display("BAD unexpected expected none seen %h", v);
      end else begin
         e = nq.pop_front();
         if (v !== e.v) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", e.nm, e.v, v);
         end
      end
   endtask

   task automatic show(logic [15:0] v);
      obs_v = v;
      obs   = 1'b1;
      @(posedge clk) #1;
      obs   = 1'b0;
   endtask

   // Edges until the next sequence start
   task automatic count_go(input int lim, output int k);
      int g;
      g = go_n;
      k = 0;
      while (go_n == g && k < lim) begin
         @(posedge clk) #1;
         k++;
      end
      // Limit ran out with no start
      if (go_n == g) num_errors++;
   endtask

   task automatic conclude();
      num_errors += nq.size();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------
   // Result watcher
   // ------------------------------
   logic        busy_p = 1'b0;
   logic        meas   = 1'b0;
   logic        st     = 1'b0;
   logic [15:0] per, bsy, sig;

   // Period, busy span and channel order of one sequence
   always @(posedge clk) begin
      if (start && !busy_p) begin
         go_n++;
         if (st) begin
            take(per);
            take(bsy);
            take(sig);
            st   = 1'b0;
            meas = 1'b0;
         end else if (meas) begin
            st  = 1'b1;
            per = 16'h0000;
            bsy = 16'h0000;
            sig = 16'h0000;
         end
      end
      if (st) begin
         per++;
         bsy += 16'(busy);
         if (start) sig = {sig[13:0], act};
      end
      if (rd_vld) take({8'h00, rd_val});
      if (obs) take(obs_v);
      busy_p = busy;
   end

   // One measured sequence at a rate code and channel mask
   task automatic run(logic [2:0] code, logic [3:0] m);
      logic [15:0] nom, cv, s;
      int k;
      nom = 16'(N) << (3'd7 - code);
      cv  = 16'($countones(m) * N);
      s   = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         if (m[i]) s = {s[13:0], 2'(i)};
      end
      host.wr_reg(`RATE_PTR, {5'h00, code});
      chan_on = m;
      count_go(3000, k);
      push("period", (nom > cv) ? nom : cv + 16'h0001);
      push("busy", cv);
      push("order", s);
      meas = 1'b1;
      while (meas && k < 9000) begin
         @(posedge clk) #1;
         k++;
      end
      // Limit ran out before the measurement closed
      if (meas) num_errors++;
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      int k;
      logic [7:0] d, t;
      logic [3:0] m;
      logic [1:0] r;
      logic [1:0] sh;
      int q;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      push("rate reset", 16'h0007);
      host.rd_reg(`RATE_PTR);
      push("unmapped", 16'h0000);
      host.rd_reg(8'h0C);
      d = 8'(xs());
      host.wr_reg(`RATE_PTR, d);
      host.wr_reg(8'h0C, ~d);
      push("rate rw", {8'h00, d});
      host.rd_reg(`RATE_PTR);
      r = 2'(xs());
      for (int i = 0; i < 4; i++) begin
         sel = 2'(i) ^ r;
         repeat (4) @(posedge clk);
         #1 push("address", {9'h000, 5'h0A, sel});
         show({9'h000, addr});
      end
      for (int c = 0; c < 8; c++) begin
         r = 2'(xs());
         for (int n = 1; n <= 4; n++) begin
            if (c >= 6 || n == int'(r) + 1) begin
               sh = 2'(xs());
               t  = {4'hF >> (4 - n), 4'hF >> (4 - n)} << sh;
               m = t[7:4];
               run(3'(c), m);
            end
         end
      end
      // Slow rate, one channel, then a one-shot in idle
      host.wr_reg(`RATE_PTR, 8'h00);
      chan_on = 4'h1;
      count_go(3000, k);
      repeat (40) @(posedge clk);
      #1 oneshot = 1'b1;
      @(posedge clk) #1;
      oneshot = 1'b0;
      count_go(10, k);
      push("oneshot", 16'h0001);
      show(16'(k));
      // Halt in the second cycle of a four-channel sequence
      host.wr_reg(`RATE_PTR, 8'h07);
      chan_on = 4'hF;
      count_go(3000, k);
      halt = 1'b1;
      k = 0;
      q = 0;
      repeat (300) begin
         @(posedge clk) #1;
         k += int'(busy);
         q += int'(done);
      end
      // First two busy cycles already seen by count_go
      push("halt busy", 16'(4 * N - 2));
      show(16'(k));
      push("seq done", 16'h0001);
      show(16'(q));
      halt = 1'b0;
      count_go(10, k);
      push("resume", 16'h0002);
      show(16'(k));
      // Enable low for 30 edges freezes the running conversion
      ce   = 1'b0;
      halt = 1'b1;
      k    = 0;
      repeat (30) begin
         @(posedge clk) #1;
         k += int'(busy);
      end
      ce = 1'b1;
      repeat (300) begin
         @(posedge clk) #1;
         k += int'(busy);
      end
      // Three busy cycles passed in count_go and show
      push("frozen busy", 16'(4 * N - 3 + 30));
      show(16'(k));
      conclude();
   end

   // Hang guard, far beyond the planned run
   initial begin
      #(10 * 100000);
      num_errors++;
      conclude();
   end
endmodule
